/* rtl/twb_pkg.sv */
// Behaviour
// (R1) data pin level held in latch
// (R2) interrupt on own address or extension code
// (R3) count serial clocks to confirm byte
// (R4) transfer interrupt at eighth or ninth fall
// (R5) stop condition interrupt when enabled
// (R6) master derives and drives serial clock
// (R7) clock-stretching waits hold the clock low
// (R8) generate and detect acknowledge, start, stop
// (R9) data changes after hold time delay
// (R10) start trigger generates start condition
// (R11) busy with reservation disabled sets fail
// (R12) stop trigger generates stop condition
// (R13) own address low bit forced zero
// (R14) both lines driven open drain
package twb_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_HALF_NS = 500;
  localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_PERIOD_NS;
  localparam int HOLD_NS = 30;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 10;
  localparam int HOLD_W = 4;
  localparam logic [HOLD_W-1:0] HOLD_ONE = 4'h1;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_OWN = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_CFG = 8'h18;
  // bus_control_register_0 fields and the configuration register field
  localparam int CTL_STOP = 0;
  localparam int CTL_START = 1;
  localparam int CTL_ACKEN = 2;
  localparam int CTL_WTIM = 3;
  localparam int CTL_SPIE = 4;
  localparam int CTL_EN = 7;
  localparam int CFG_RSVDIS = 0;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_START_FAIL_FLAG = 1;
  localparam int ST_MSTR = 2;
  localparam int ST_ACK = 3;
  localparam int ST_MATCH = 4;
  localparam int ST_EXT = 5;
  localparam int ST_TRC = 6;
  localparam int ST_WAIT = 7;
  // interrupt status and mask fields
  localparam int IRQ_W = 5;
  localparam int IRQ_XFER = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_MATCH = 2;
  localparam int IRQ_EXT = 3;
  localparam int IRQ_START_FAIL_FLAG = 4;
  // clock counter marks, extension codes and bus response codes
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_LAST = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_PRE = 4'hF;
  localparam logic [3:0] EXT_GCALL = 4'h0;
  localparam logic [4:0] EXT_TENBIT = 5'h1E;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [3:0] {
    M_IDLE, M_START, M_START_LOW, M_LOW, M_HIGH,
    M_STOP_LOW, M_STOP_HIGH, M_STOP_END, M_RS_SDA, M_RS_SCL
  } mstate_t;
endpackage : twb_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 2
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // idle bus lines float high, so reset to ones
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule : pin_sync

/* rtl/tick_div.sv */
`timescale 1ns/10ps
module tick_div #(
  parameter int DIV = 2
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  output logic tick_o
);
  localparam int W = twb_pkg::DIV_W;
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  // restarts from zero whenever stopped, so the first half period is full
  always_comb begin
    cnt_d = cnt_q + 1'h1;
    tick_d = 1'h0;
    if (!run_i) begin
      cnt_d = '0;
    end else if (cnt_q == LAST) begin
      cnt_d = '0;
      tick_d = 1'h1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      tick_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign tick_o = tick_q;
endmodule : tick_div

/* rtl/two_wire_bus_controller.sv */
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module two_wire_bus_controller (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o,
  output logic irq_o
);
  typedef struct packed {
    logic aw_full, w_full, awready, wready, bvalid, arready, rvalid, wstb;
    logic [7:0] awaddr, wdata, rdata;
    logic [1:0] bresp, rresp;
  } axi_t;
  typedef struct packed {
    logic [7:0] ctrl, own, tx_sh, rx_sh, rxd;
    logic [twb_pkg::IRQ_W-1:0] irq, mask;
    logic rsvdis, irq_out, busy, start_fail_flag, master, ack, match, ext, trc;
    logic wait_f, addr_ph, ackd, reserve, hold_run, sda_low, scl_low, scl_oe;
    logic scl_p, sda_p;
    logic [3:0] cnt;
    logic [twb_pkg::HOLD_W-1:0] hold;
    twb_pkg::mstate_t ms;
  } core_t;

  axi_t ax_q, ax_d;
  core_t c_q, c_d;
  logic wr_en, rd_en, wr_hit, rd_hit, tick, scl_s, sda_s;
  logic [7:0] rd_val, stat;

  // both pins pass two flops before any logic reads them
  pin_sync #(.W(2)) u_sync (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .pin_i({serial_clock_pin_i, serial_data_pin_i}),
    .sync_o({scl_s, sda_s})
  );
  // (R6) half-period pacing for the master clock
  tick_div #(.DIV(twb_pkg::SCL_HALF_CYC)) u_div (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .run_i(c_q.ms != twb_pkg::M_IDLE),
    .tick_o(tick)
  );

  // line events seen on the sampled pins
  logic scl_rise, scl_fall, start_det, stop_det, hold_fire;
  // (R8) start and stop detection
  assign start_det = scl_s && c_q.scl_p && c_q.sda_p && !sda_s;
  assign stop_det = scl_s && c_q.scl_p && !c_q.sda_p && sda_s;
  assign scl_rise = scl_s && !c_q.scl_p;
  assign scl_fall = !scl_s && c_q.scl_p;
  assign hold_fire = c_q.hold_run && (c_q.hold == twb_pkg::HOLD_ONE);

  // register strobes
  logic ctl_wr, data_wr, rd_irq;
  assign ctl_wr = wr_en && ax_q.wstb && (ax_q.awaddr == twb_pkg::OFF_CTRL);
  assign data_wr = wr_en && ax_q.wstb && (ax_q.awaddr == twb_pkg::OFF_DATA);
  assign rd_irq = rd_en && (araddr_i == twb_pkg::OFF_IRQ);

  // write decode, unmapped addresses answer decode error
  always_comb begin
    wr_hit = 1'h1;
    if (ax_q.awaddr == twb_pkg::OFF_CTRL) begin
      wr_hit = 1'h1;
    end else if (ax_q.awaddr == twb_pkg::OFF_DATA) begin
      wr_hit = 1'h1;
    end else if (ax_q.awaddr == twb_pkg::OFF_OWN) begin
      wr_hit = 1'h1;
    end else if (ax_q.awaddr == twb_pkg::OFF_STAT) begin
      wr_hit = 1'h1;
    end else if (ax_q.awaddr == twb_pkg::OFF_IRQ) begin
      wr_hit = 1'h1;
    end else if (ax_q.awaddr == twb_pkg::OFF_MASK) begin
      wr_hit = 1'h1;
    end else if (ax_q.awaddr == twb_pkg::OFF_CFG) begin
      wr_hit = 1'h1;
    end else begin
      wr_hit = 1'h0;
    end
  end

  // status word
  always_comb begin
    stat = '0;
    stat[twb_pkg::ST_BUSY] = c_q.busy;
    stat[twb_pkg::ST_START_FAIL_FLAG] = c_q.start_fail_flag;
    stat[twb_pkg::ST_MSTR] = c_q.master;
    stat[twb_pkg::ST_ACK] = c_q.ack;
    stat[twb_pkg::ST_MATCH] = c_q.match;
    stat[twb_pkg::ST_EXT] = c_q.ext;
    stat[twb_pkg::ST_TRC] = c_q.trc;
    stat[twb_pkg::ST_WAIT] = c_q.wait_f;
  end

  // read decode
  always_comb begin
    rd_hit = 1'h1;
    rd_val = '0;
    if (araddr_i == twb_pkg::OFF_CTRL) begin
      rd_val = c_q.ctrl;
    end else if (araddr_i == twb_pkg::OFF_DATA) begin
      rd_val = c_q.rxd;
    end else if (araddr_i == twb_pkg::OFF_OWN) begin
      rd_val = c_q.own;
    end else if (araddr_i == twb_pkg::OFF_STAT) begin
      rd_val = stat;
    end else if (araddr_i == twb_pkg::OFF_IRQ) begin
      rd_val = 8'(c_q.irq);
    end else if (araddr_i == twb_pkg::OFF_MASK) begin
      rd_val = 8'(c_q.mask);
    end else if (araddr_i == twb_pkg::OFF_CFG) begin
      rd_val = 8'(c_q.rsvdis);
    end else begin
      rd_hit = 1'h0;
    end
  end

  // bus slave: address and data taken in either order, write one cycle later
  always_comb begin
    ax_d = ax_q;
    wr_en = 1'h0;
    rd_en = 1'h0;
    if (awvalid_i && ax_q.awready) begin
      ax_d.aw_full = 1'h1;
      ax_d.awaddr = awaddr_i;
    end
    if (wvalid_i && ax_q.wready) begin
      ax_d.w_full = 1'h1;
      ax_d.wdata = wdata_i[7:0];
      ax_d.wstb = wstrb_i[0];
    end
    if (ax_q.aw_full && ax_q.w_full && !ax_q.bvalid) begin
      wr_en = 1'h1;
      ax_d.aw_full = 1'h0;
      ax_d.w_full = 1'h0;
      ax_d.bvalid = 1'h1;
      ax_d.bresp = wr_hit ? twb_pkg::RESP_OKAY : twb_pkg::RESP_DECERR;
    end
    if (ax_q.bvalid && bready_i) begin
      ax_d.bvalid = 1'h0;
    end
    if (arvalid_i && ax_q.arready) begin
      rd_en = 1'h1;
      ax_d.rvalid = 1'h1;
      ax_d.rdata = rd_val;
      ax_d.rresp = rd_hit ? twb_pkg::RESP_OKAY : twb_pkg::RESP_DECERR;
    end
    if (ax_q.rvalid && rready_i) begin
      ax_d.rvalid = 1'h0;
    end
    ax_d.awready = !ax_d.aw_full;
    ax_d.wready = !ax_d.w_full;
    ax_d.arready = !ax_d.rvalid;
  end
  always_ff @(posedge ref_clk_i) begin
    ax_q <= srst_i ? '0 : ax_d;
  end

  // protocol engine
  always_comb begin
    logic hit;
    logic ext_hit;
    logic inv;
    logic [twb_pkg::IRQ_W-1:0] ev;
    hit = (c_q.rx_sh[7:1] == c_q.own[7:1]);
    ext_hit = (c_q.rx_sh[7:4] == twb_pkg::EXT_GCALL) || (c_q.rx_sh[7:3] == twb_pkg::EXT_TENBIT);
    inv = 1'h0;
    ev = '0;
    c_d = c_q;
    c_d.scl_p = scl_s;
    c_d.sda_p = sda_s;
    // plain register writes; trigger bits never stored
    if (ctl_wr) begin
      c_d.ctrl = ax_q.wdata;
      c_d.ctrl[twb_pkg::CTL_START] = 1'h0;
      c_d.ctrl[twb_pkg::CTL_STOP] = 1'h0;
    end
    // (R13) low bit of own address stays zero
    if (wr_en && ax_q.wstb && ax_q.awaddr == twb_pkg::OFF_OWN) begin
      c_d.own = {ax_q.wdata[7:1], 1'h0};
    end
    if (wr_en && ax_q.wstb && ax_q.awaddr == twb_pkg::OFF_MASK) begin
      c_d.mask = ax_q.wdata[twb_pkg::IRQ_W-1:0];
    end
    if (wr_en && ax_q.wstb && ax_q.awaddr == twb_pkg::OFF_CFG) begin
      c_d.rsvdis = ax_q.wdata[twb_pkg::CFG_RSVDIS];
    end
    // (R7) data write ends the wait; a pending first bit is redriven at once
    if (data_wr) begin
      c_d.tx_sh = ax_q.wdata;
      c_d.wait_f = 1'h0;
      if (c_q.wait_f && c_q.trc && c_q.cnt == twb_pkg::CNT_ZERO) begin
        c_d.sda_low = !ax_q.wdata[7];
        c_d.tx_sh = {ax_q.wdata[6:0], 1'h1};
        c_d.hold_run = 1'h0;
      end
    end
    if (start_det) begin
      c_d.busy = 1'h1;
      c_d.cnt = twb_pkg::CNT_PRE;
      c_d.addr_ph = 1'h1;
      c_d.match = 1'h0;
      c_d.ext = 1'h0;
      c_d.trc = c_q.master;
    end
    // (R5) stop condition interrupt, gated by enable
    if (stop_det) begin
      c_d.busy = 1'h0;
      c_d.cnt = twb_pkg::CNT_PRE;
      c_d.addr_ph = 1'h0;
      c_d.match = 1'h0;
      c_d.ext = 1'h0;
      c_d.trc = 1'h0;
      c_d.wait_f = 1'h0;
      c_d.sda_low = 1'h0;
      ev[twb_pkg::IRQ_STOP] = c_q.ctrl[twb_pkg::CTL_SPIE];
      if (c_q.reserve) begin
        c_d.reserve = 1'h0;
        c_d.master = 1'h1;
        c_d.ms = twb_pkg::M_START;
      end
    end
    // (R8) sample data and acknowledge on rising clock
    if (scl_rise && c_q.busy) begin
      if (c_q.cnt < twb_pkg::CNT_ACK) begin
        c_d.rx_sh = {c_q.rx_sh[6:0], sda_s};
      end else if (c_q.cnt == twb_pkg::CNT_ACK) begin
        c_d.ack = !sda_s;
      end
    end
    // (R3) count falling clocks; the fall after the start is not a data bit
    if (scl_fall && c_q.busy) begin
      c_d.cnt = (c_q.cnt == twb_pkg::CNT_ACK) ? twb_pkg::CNT_ZERO : c_q.cnt + 4'h1;
      c_d.hold_run = 1'h1;
      c_d.hold = twb_pkg::HOLD_W'(twb_pkg::HOLD_CYC);
      if (c_q.cnt == twb_pkg::CNT_LAST) begin
        c_d.rxd = c_q.rx_sh;
        if (c_q.addr_ph) begin
          c_d.addr_ph = 1'h0;
          if (c_q.master) begin
            c_d.trc = !c_q.rx_sh[0];
          end else begin
            // (R2) own address or extension code raises the request
            c_d.match = hit;
            c_d.ext = ext_hit;
            c_d.trc = hit && c_q.rx_sh[0];
            ev[twb_pkg::IRQ_MATCH] = hit;
            ev[twb_pkg::IRQ_EXT] = ext_hit;
          end
          c_d.ackd = !c_q.master && (hit || ext_hit);
        end else begin
          c_d.ackd = !c_q.trc && (c_q.master || c_q.match || c_q.ext);
        end
        inv = c_q.master || c_d.match || c_d.ext;
        // (R4) eighth-fall interrupt and wait
        if (!c_q.ctrl[twb_pkg::CTL_WTIM] && inv) begin
          c_d.wait_f = 1'h1;
          ev[twb_pkg::IRQ_XFER] = 1'h1;
        end
      end else if (c_q.cnt == twb_pkg::CNT_ACK) begin
        inv = c_q.master || c_q.match || c_q.ext;
        // (R4) ninth-fall interrupt and wait
        if (c_q.ctrl[twb_pkg::CTL_WTIM] && inv) begin
          c_d.wait_f = 1'h1;
          ev[twb_pkg::IRQ_XFER] = 1'h1;
        end
        // slave transmitter lets go after a missing acknowledge
        if (c_q.trc && !c_q.ack && !c_q.master) begin
          c_d.trc = 1'h0;
        end
      end
    end else if (hold_fire) begin
      // (R9) data or acknowledge changes only after the hold delay
      c_d.hold_run = 1'h0;
      if (c_q.cnt == twb_pkg::CNT_ACK) begin
        c_d.sda_low = c_q.ackd && c_q.ctrl[twb_pkg::CTL_ACKEN];
      end else begin
        // (R1) output latch keeps the level between updates
        c_d.sda_low = c_q.trc && !c_q.tx_sh[7];
        c_d.tx_sh = {c_q.tx_sh[6:0], 1'h1};
      end
    end else if (c_q.hold_run) begin
      c_d.hold = c_q.hold - twb_pkg::HOLD_ONE;
    end
    // (R6) master clock sequencing, paced by the divider
    case (c_q.ms)
      twb_pkg::M_START: if (tick) begin
        c_d.sda_low = 1'h1;
        c_d.ms = twb_pkg::M_START_LOW;
      end
      twb_pkg::M_START_LOW: if (tick) begin
        c_d.scl_low = 1'h1;
        c_d.wait_f = 1'h1;
        c_d.ms = twb_pkg::M_LOW;
      end
      twb_pkg::M_LOW: if (tick && !c_d.wait_f) begin
        c_d.scl_low = 1'h0;
        c_d.ms = twb_pkg::M_HIGH;
      end
      // a slave stretching the clock holds us here
      twb_pkg::M_HIGH: if (tick && scl_s) begin
        c_d.scl_low = 1'h1;
        c_d.ms = twb_pkg::M_LOW;
      end
      twb_pkg::M_STOP_LOW: if (tick) begin
        c_d.scl_low = 1'h1;
        c_d.sda_low = 1'h1;
        c_d.ms = twb_pkg::M_STOP_HIGH;
      end
      twb_pkg::M_STOP_HIGH: if (tick) begin
        c_d.scl_low = 1'h0;
        c_d.ms = twb_pkg::M_STOP_END;
      end
      twb_pkg::M_STOP_END: if (tick && scl_s) begin
        c_d.sda_low = 1'h0;
        c_d.master = 1'h0;
        c_d.ms = twb_pkg::M_IDLE;
      end
      twb_pkg::M_RS_SDA: if (tick) begin
        c_d.sda_low = 1'h0;
        c_d.ms = twb_pkg::M_RS_SCL;
      end
      twb_pkg::M_RS_SCL: if (tick) begin
        c_d.scl_low = 1'h0;
        c_d.ms = twb_pkg::M_START;
      end
      default: ;
    endcase
    // (R10) start trigger; restart when already master
    if (ctl_wr && ax_q.wdata[twb_pkg::CTL_START]) begin
      c_d.hold_run = 1'h0;
      if (c_q.master) begin
        c_d.wait_f = 1'h0;
        c_d.ms = twb_pkg::M_RS_SDA;
      end else if (!c_q.busy) begin
        c_d.master = 1'h1;
        c_d.start_fail_flag = 1'h0;
        c_d.ms = twb_pkg::M_START;
      end else if (c_q.rsvdis) begin
        // (R11) busy bus with reservation off: drop it and flag failure
        c_d.start_fail_flag = 1'h1;
        ev[twb_pkg::IRQ_START_FAIL_FLAG] = 1'h1;
      end else begin
        c_d.reserve = 1'h1;
      end
    end
    // (R12) stop trigger
    if (ctl_wr && ax_q.wdata[twb_pkg::CTL_STOP] && c_q.master) begin
      c_d.wait_f = 1'h0;
      c_d.hold_run = 1'h0;
      c_d.reserve = 1'h0;
      c_d.ms = twb_pkg::M_STOP_LOW;
    end
    // disabled block lets go of both lines
    if (!c_d.ctrl[twb_pkg::CTL_EN]) begin
      c_d.ms = twb_pkg::M_IDLE;
      c_d.master = 1'h0;
      c_d.scl_low = 1'h0;
      c_d.sda_low = 1'h0;
      c_d.wait_f = 1'h0;
      c_d.match = 1'h0;
      c_d.trc = 1'h0;
      c_d.hold_run = 1'h0;
      c_d.reserve = 1'h0;
    end
    // sticky events: a read clears, a new event in the same cycle wins
    c_d.irq = (rd_irq ? '0 : c_q.irq) | ev;
    c_d.irq_out = |(c_d.irq & c_d.mask);
    // (R7) clock held low by the master phase or by a wait
    c_d.scl_oe = c_d.scl_low || c_d.wait_f;
  end
  // line history resets to the idle high level, so no false edge follows reset
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      c_q <= '0;
      c_q.scl_p <= 1'h1;
      c_q.sda_p <= 1'h1;
    end else begin
      c_q <= c_d;
    end
  end

  assign awready_o = ax_q.awready;
  assign wready_o = ax_q.wready;
  assign bvalid_o = ax_q.bvalid;
  assign bresp_o = ax_q.bresp;
  assign arready_o = ax_q.arready;
  assign rvalid_o = ax_q.rvalid;
  assign rresp_o = ax_q.rresp;
  assign rdata_o = {24'h000000, ax_q.rdata};
  assign irq_o = c_q.irq_out;
  // (R14) open drain: only ever pull low
  assign serial_clock_pin_o = 1'h0;
  assign serial_data_pin_o = 1'h0;
  assign serial_clock_pin_oe_o = c_q.scl_oe;
  assign serial_data_pin_oe_o = c_q.sda_low;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  own_lsb_a: assert property (c_q.own[0] == 1'h0) // (R13)
    else $error("own address low bit set");
  start_fail_a: assert property (ctl_wr && ax_q.wdata[twb_pkg::CTL_START] && c_q.busy // (R11)
    && !c_q.master && c_q.rsvdis |=> c_q.start_fail_flag && c_q.irq[twb_pkg::IRQ_START_FAIL_FLAG] && !c_q.master)
    else $error("busy start not refused");
  start_gen_a: assert property (ctl_wr && ax_q.wdata[twb_pkg::CTL_START] // (R10)
    && ax_q.wdata[twb_pkg::CTL_EN] && !c_q.busy && !c_q.master |=> c_q.ms == twb_pkg::M_START)
    else $error("start not begun");
  stop_gen_a: assert property (ctl_wr && ax_q.wdata[twb_pkg::CTL_STOP] // (R12)
    && ax_q.wdata[twb_pkg::CTL_EN] && c_q.master |=> c_q.ms == twb_pkg::M_STOP_LOW)
    else $error("stop not begun");
  xfer_irq_a: assert property (scl_fall && c_q.busy && c_q.master && !data_wr && !ctl_wr // (R4)
    && c_q.cnt == twb_pkg::CNT_LAST && !c_q.ctrl[twb_pkg::CTL_WTIM] && c_q.ctrl[twb_pkg::CTL_EN]
    |=> c_q.irq[twb_pkg::IRQ_XFER] && c_q.wait_f && serial_clock_pin_oe_o)
    else $error("no eighth-fall interrupt");
  stop_irq_a: assert property (stop_det && c_q.ctrl[twb_pkg::CTL_SPIE] // (R5)
    |=> c_q.irq[twb_pkg::IRQ_STOP] && !c_q.busy)
    else $error("stop interrupt missing");
  hold_time_a: assert property (scl_fall && c_q.busy && c_q.ms == twb_pkg::M_IDLE // (R9)
    && !ctl_wr && !data_wr |=> $stable(serial_data_pin_oe_o) [*2])
    else $error("data changed within hold time");
  count_wrap_a: assert property (scl_fall && c_q.busy && c_q.cnt == twb_pkg::CNT_ACK // (R3)
    && !start_det && !stop_det |=> c_q.cnt == twb_pkg::CNT_ZERO)
    else $error("clock count did not wrap");
  ack_sample_a: assert property (scl_rise && c_q.busy && c_q.cnt == twb_pkg::CNT_ACK // (R8)
    |=> c_q.ack == !$past(sda_s))
    else $error("acknowledge not sampled");
  wait_hold_a: assert property (c_q.wait_f |-> serial_clock_pin_oe_o) // (R7)
    else $error("clock released during wait");
  master_clk_a: assert property (c_q.ms == twb_pkg::M_HIGH && tick && scl_s // (R6)
    && c_q.ctrl[twb_pkg::CTL_EN] && !ctl_wr |=> serial_clock_pin_oe_o)
    else $error("master clock not driven low");
  irq_level_a: assert property ((c_q.irq & c_q.mask) != '0 && !rd_irq // (R2)
    && !(wr_en && ax_q.awaddr == twb_pkg::OFF_MASK) |=> irq_o)
    else $error("unmasked event not signalled");
  open_drain_a: assert property (!serial_data_pin_o && !serial_clock_pin_o) // (R14)
    else $error("pin driven high");
  start_c: cover property (c_q.ms == twb_pkg::M_START ##1 c_q.ms == twb_pkg::M_START_LOW);
  match_c: cover property (c_q.irq[twb_pkg::IRQ_MATCH]);
  stop_c: cover property (c_q.irq[twb_pkg::IRQ_STOP] && irq_o);
  fail_c: cover property (c_q.start_fail_flag);
endmodule : two_wire_bus_controller

/* tb/far_master.sv */
`timescale 1ns/10ps
module far_master (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  // 160 ns bit: hold 20, setup 60, high 80; clock idles released
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  // lines are only pulled low or let go
  task automatic start_frame();
    sda_oe_o = 1'b1;
    #80 scl_oe_o = 1'b1;
  endtask : start_frame
  // a stretched low phase is waited out
  task automatic pulse(output logic lvl);
    #60 scl_oe_o = 1'b0;
    wait (scl_i === 1'b1);
    lvl = sda_i;
    #80 scl_oe_o = 1'b1;
  endtask : pulse
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic lvl;
    for (int i = 7; i >= 0; i--) begin
      #20 sda_oe_o = !b[i];
      pulse(lvl);
    end
    #20 sda_oe_o = 1'b0;
    pulse(lvl);
    acked = !lvl;
  endtask : send_byte
  // stop: data rises while clock high
  task automatic stop_frame();
    #20 sda_oe_o = 1'b1;
    #60 scl_oe_o = 1'b0;
    wait (scl_i === 1'b1);
    #80 sda_oe_o = 1'b0;
  endtask : stop_frame
endmodule : far_master

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0] wstrb_i = 4'hF;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
  logic [1:0] bresp_o, rresp_o, r;
  logic [31:0] rdata_o, v;
  logic serial_clock_pin_o, serial_clock_pin_oe_o, serial_data_pin_o, serial_data_pin_oe_o;
  logic far_scl_oe, far_sda_oe, ack;
  int mismatches = 0, num_checks = 0, cycles = 0, rises = 0;
  realtime t_fall = 0.0;
  wire scl = !(serial_clock_pin_oe_o || far_scl_oe);
  wire sda = !(serial_data_pin_oe_o || far_sda_oe);
  wire serial_clock_pin_i = scl;
  wire serial_data_pin_i = sda;
  two_wire_bus_controller u_dut (.ref_clk_i, .srst_i, .awaddr_i, .awvalid_i, .awready_o,
    .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i,
    .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .serial_clock_pin_i,
    .serial_clock_pin_o, .serial_clock_pin_oe_o, .serial_data_pin_i, .serial_data_pin_o,
    .serial_data_pin_oe_o, .irq_o);
  far_master u_far (.scl_i(scl), .sda_i(sda), .scl_oe_o(far_scl_oe), .sda_oe_o(far_sda_oe));
  always #5 ref_clk_i = !ref_clk_i;
  // traffic needs about 2000 cycles, so a hang shows well before this
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  // line monitors
  always @(negedge scl) t_fall = $realtime;
  always @(posedge scl) rises++;
  always @(posedge serial_data_pin_oe_o)
    if (scl === 1'b0) check("hold", 32'($realtime - t_fall >= twb_pkg::HOLD_NS), 32'h1);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // both channels offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (awready_o === 1'b1) awvalid_i <= 1'b0;
      if (wready_o === 1'b1) wvalid_i <= 1'b0;
    end while (bvalid_o !== 1'b1);
    r = bresp_o;
    bready_i <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge ref_clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (arready_o === 1'b1) arvalid_i <= 1'b0;
    end while (rvalid_o !== 1'b1);
    d = rdata_o;
    rs = rresp_o;
    rready_i <= 1'b0;
  endtask : axi_read
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] d;
    logic [1:0] rs;
    axi_read(a, d, rs);
    check(what, d, e);
  endtask : rd_chk
  function automatic logic pick(input int s);
    return (s == 0) ? scl : (s == 1) ? sda : irq_o;
  endfunction : pick
  // bounded wait on clock line, data line or interrupt
  task automatic wait_for(input int s, input logic lvl);
    for (int k = 0; k < 3000 && pick(s) !== lvl; k++) @(posedge ref_clk_i);
    check("line wait", pick(s), lvl);
  endtask : wait_for
  initial begin
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd_chk(twb_pkg::OFF_CTRL, 32'h0, "ctrl reset");
    rd_chk(twb_pkg::OFF_STAT, 32'h0, "status reset");
    axi_read(8'h1C, v, r);
    check("unmapped", {v[29:0], r}, 32'h3);
    axi_write(8'h1C, 32'h0);
    check("unmapped write", r, 32'h3);
    axi_write(twb_pkg::OFF_OWN, 32'hA5);
    check("write okay", r, 32'h0);
    rd_chk(twb_pkg::OFF_OWN, 32'hA4, "own address");
    axi_write(twb_pkg::OFF_MASK, 32'h1F);
    // addressed slave, wait at eighth fall
    axi_write(twb_pkg::OFF_CTRL, 32'h94);
    u_far.start_frame();
    fork
      u_far.send_byte(8'hA4, ack);
      begin
        wait_for(2, 1'b1);
        rd_chk(twb_pkg::OFF_IRQ, 32'h05, "match irq");
        axi_write(twb_pkg::OFF_DATA, 32'h0);
      end
    join
    check("address ack", ack, 32'h1);
    // data byte, wait at ninth fall, then stop
    axi_write(twb_pkg::OFF_CTRL, 32'h9C);
    u_far.send_byte(8'h3C, ack);
    wait_for(2, 1'b1);
    check("data ack", ack, 32'h1);
    rd_chk(twb_pkg::OFF_IRQ, 32'h01, "ninth fall irq");
    rd_chk(twb_pkg::OFF_DATA, 32'h3C, "rx byte");
    axi_write(twb_pkg::OFF_DATA, 32'h0);
    u_far.stop_frame();
    wait_for(2, 1'b1);
    rd_chk(twb_pkg::OFF_IRQ, 32'h02, "stop irq");
    // extension code
    u_far.start_frame();
    u_far.send_byte(8'h00, ack);
    wait_for(2, 1'b1);
    axi_read(twb_pkg::OFF_IRQ, v, r);
    check("ext irq", v & 32'h08, 32'h08);
    axi_write(twb_pkg::OFF_DATA, 32'h0);
    u_far.stop_frame();
    // the read dropped irq, and the stop needs a few cycles to be seen, so give it time to land first
    repeat (8) @(posedge ref_clk_i);
    axi_read(twb_pkg::OFF_IRQ, v, r);
    check("ext stop irq", v & 32'h02, 32'h02);
    // start refused on a busy bus, interrupt masked then let through
    axi_write(twb_pkg::OFF_MASK, 32'h0);
    axi_write(twb_pkg::OFF_CFG, 32'h1);
    u_far.start_frame();
    axi_write(twb_pkg::OFF_CTRL, 32'h82);
    axi_read(twb_pkg::OFF_STAT, v, r);
    check("start refused", v & 32'h07, 32'h03);
    check("irq masked", irq_o, 32'h0);
    axi_write(twb_pkg::OFF_MASK, 32'h1F);
    wait_for(2, 1'b1);
    rd_chk(twb_pkg::OFF_IRQ, 32'h10, "fail irq");
    repeat (2) @(posedge ref_clk_i);
    check("irq cleared", irq_o, 32'h0);
    u_far.stop_frame();
    axi_write(twb_pkg::OFF_CFG, 32'h0);
    // master frame nobody answers, wait at ninth fall
    axi_write(twb_pkg::OFF_CTRL, 32'h8A);
    wait_for(1, 1'b0);
    check("start clock high", scl, 32'h1);
    wait_for(0, 1'b0);
    axi_read(twb_pkg::OFF_IRQ, v, r);
    rises = 0;
    axi_write(twb_pkg::OFF_DATA, 32'hA0);
    wait_for(2, 1'b1);
    check("clock count", rises, 32'd9);
    rd_chk(twb_pkg::OFF_IRQ, 32'h01, "master irq");
    axi_read(twb_pkg::OFF_STAT, v, r);
    check("nack seen", v & 32'h0C, 32'h04);
    repeat (100) @(posedge ref_clk_i);
    check("clock held", scl, 32'h0);
    axi_write(twb_pkg::OFF_CTRL, 32'h89);
    wait_for(1, 1'b0);
    wait_for(0, 1'b1);
    wait_for(1, 1'b1);
    check("stop clock high", scl, 32'h1);
    check("open drain", {serial_clock_pin_o, serial_data_pin_o}, 32'h0);
    end_of_test();
  end
endmodule : testbench
